// ===== bit_sync.sv
// two flip-flop synchroniser for a pin level
`timescale 1ns/1ps
module bit_sync (
   // clock and reset
   input  wire logic mclk_i,
   input  wire logic arst_n_i,
   // level
   input  wire logic d_i,
   output logic      q_o
);

   logic meta_ff;

   always_ff @(posedge mclk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         meta_ff <= 1'b0;
         q_o     <= 1'b0;
      end else begin
         meta_ff <= d_i;
         q_o     <= meta_ff;
      end
   end

endmodule : bit_sync

// ===== lmfc_align_ctrl.sv
// lmfc to sysref alignment control with its register file
`timescale 1ns/1ps
module lmfc_align_ctrl (
   // clock and reset
   input  wire logic                                     mclk_i,
   input  wire logic                                     arst_n_i,
   // sysref pin
   input  wire logic                                     sysref_i,
   // link configuration
   input  wire logic [lmfc_align_pkg::SUBCLASS_W-1:0]    subclass_i,
   input  wire logic [lmfc_align_pkg::INTERP_W-1:0]      interp_factor_i,
   // register port
   input  wire logic                                     reg_wr_i,
   input  wire logic                                     reg_rd_i,
   input  wire logic [lmfc_align_pkg::ADDR_W-1:0]        reg_addr_i,
   input  wire logic [lmfc_align_pkg::DATA_W-1:0]        reg_wdata_i,
   output logic      [lmfc_align_pkg::DATA_W-1:0]        reg_rdata_o,
   // local multiframe clock
   output logic                                          lmfc_pulse_o
);

   import lmfc_align_pkg::*;

   logic                  sref_lvl;
   logic                  sref_pulse;
   logic                  clr_sticky_pulse;
   logic                  clr_last_pulse;
   logic [WIN_W-1:0]      window_ff;
   logic [DATA_W-1:0]     ctrl_ff;
   logic [ERR_W-1:0]      last_err_ff;
   logic                  under_ff;
   logic                  over_ff;
   logic [ERR_W-1:0]      live_err_ff;
   logic                  wlim_ff;
   logic                  lock_ff;
   logic                  rotate_ff;
   logic                  trip_ff;
   logic                  chk_subclass_ff;
   logic                  chk_interp_ff;
   logic [ERR_W-1:0]      cnt_ff;
   logic [ERR_W-1:0]      nxt_cnt;
   logic [DATA_W-1:0]     rd_mux;
   align_state_type       state_ff;
   align_state_type       nxt_state;

   // sysref crosses in from the pin, then becomes an edge pulse
   bit_sync u_sref_sync (
      .mclk_i   (mclk_i),
      .arst_n_i (arst_n_i),
      .d_i      (sysref_i),
      .q_o      (sref_lvl)
   );

   rise_detect u_sref_edge (
      .mclk_i   (mclk_i),
      .arst_n_i (arst_n_i),
      .d_i      (sref_lvl),
      .rise_o   (sref_pulse)
   );

   // clear strobes fire on the stored bit's rising edge only
   rise_detect u_clr_sticky (
      .mclk_i   (mclk_i),
      .arst_n_i (arst_n_i),
      .d_i      (ctrl_ff[CTRL_CLR_STICKY_BIT]),
      .rise_o   (clr_sticky_pulse)
   );

   rise_detect u_clr_last (
      .mclk_i   (mclk_i),
      .arst_n_i (arst_n_i),
      .d_i      (ctrl_ff[CTRL_CLR_LAST_BIT]),
      .rise_o   (clr_last_pulse)
   );

   // decode
   wire wr_window = reg_wr_i && (reg_addr_i == OFS_WINDOW);
   wire wr_ctrl   = reg_wr_i && (reg_addr_i == OFS_CTRL);
   wire arm_req   = wr_ctrl && reg_wdata_i[CTRL_ARM_BIT];
   wire align_on  = ctrl_ff[CTRL_ENABLE_BIT];
   wire [MODE_W-1:0] mode = ctrl_ff[MODE_W-1:0];

   wire mode_one_shot = (mode == MODE_ONE_SHOT) ||
                        (mode == MODE_ONE_SHOT_MON);
   wire mode_cont     = (mode == MODE_CONTINUOUS);

   // window compare in five signed bits so -3..3 never wraps
   wire [ERR_W:0] err_ext = {cnt_ff[ERR_W-1], cnt_ff};
   wire [ERR_W:0] win_ext = {3'h0, window_ff};
   wire [ERR_W:0] neg_win = 5'h00 - win_ext;
   wire below   = $signed(err_ext) < $signed(neg_win);
   wire above   = $signed(err_ext) > $signed(win_ext);
   wire outside = below || above;

   // sysref is ignored entirely while the logic is off
   wire sref_live  = align_on && sref_pulse;
   wire may_adjust = mode_cont ||
                     (mode_one_shot && (state_ff == ST_ARMED));
   wire start_adjust = sref_live && may_adjust && outside &&
                       (state_ff != ST_ADJUST);
   wire trip_event = sref_live && (state_ff == ST_ARMED);
   wire busy       = (state_ff != ST_IDLE);

   always_comb begin
      nxt_state = state_ff;
      case (state_ff)
         ST_IDLE: begin
            if (start_adjust) begin
               nxt_state = ST_ADJUST;
            end else if (arm_req) begin
               nxt_state = ST_ARMED;
            end
         end
         ST_ARMED: begin
            if (start_adjust) begin
               nxt_state = ST_ADJUST;
            end else if (trip_event) begin
               // inside the window, or in a mode that never adjusts: the arm is spent with no rotation
               nxt_state = ST_IDLE;
            end
         end
         ST_ADJUST: begin
            nxt_state = ST_IDLE;
         end
         default: begin
            nxt_state = ST_IDLE;
         end
      endcase
   end

   assign nxt_cnt = (state_ff == ST_ADJUST) ? ALIGN_RELOAD
                                            : cnt_ff + CNT_STEP;

   always_ff @(posedge mclk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         state_ff     <= ST_IDLE;
         cnt_ff       <= LMFC_EDGE;
         lmfc_pulse_o <= 1'b0;
      end else begin
         state_ff     <= nxt_state;
         cnt_ff       <= nxt_cnt;
         lmfc_pulse_o <= (nxt_cnt == LMFC_EDGE);
      end
   end

   // writable registers
   always_ff @(posedge mclk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         window_ff <= WINDOW_RESET;
         ctrl_ff   <= CTRL_RESET;
      end else begin
         if (wr_window) begin
            window_ff <= reg_wdata_i[WIN_W-1:0];
         end
         if (wr_ctrl) begin
            ctrl_ff <= reg_wdata_i;
         end
      end
   end

   // live error: sampled on each sysref, zeroed by the adjustment
   always_ff @(posedge mclk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         live_err_ff <= ERR_ZERO;
         wlim_ff     <= 1'b0;
         lock_ff     <= 1'b0;
      end else if (state_ff == ST_ADJUST) begin
         live_err_ff <= ERR_ZERO;
      end else if (sref_live) begin
         live_err_ff <= cnt_ff;
         wlim_ff     <= outside;
         lock_ff     <= !outside;
      end
   end

   // recorded error; a new record beats a clear in the same cycle
   always_ff @(posedge mclk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         last_err_ff <= ERR_ZERO;
         under_ff    <= 1'b0;
         over_ff     <= 1'b0;
      end else if (start_adjust) begin
         last_err_ff <= cnt_ff;
         under_ff    <= below;
         over_ff     <= above;
      end else if (clr_last_pulse) begin
         last_err_ff <= ERR_ZERO;
         under_ff    <= 1'b0;
         over_ff     <= 1'b0;
      end
   end

   // sticky status: set wins over clear
   always_ff @(posedge mclk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         rotate_ff <= 1'b0;
         trip_ff   <= 1'b0;
      end else begin
         rotate_ff <= (state_ff == ST_ADJUST) ||
                      (rotate_ff && !clr_sticky_pulse);
         trip_ff   <= trip_event ||
                      (trip_ff && !clr_sticky_pulse);
      end
   end

   // configuration checks
   always_ff @(posedge mclk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         chk_subclass_ff <= 1'b0;
         chk_interp_ff   <= 1'b0;
      end else begin
         chk_subclass_ff <= !((subclass_i == SUBCLASS_0) ||
                              (subclass_i == SUBCLASS_1));
         chk_interp_ff   <= !((interp_factor_i == INTERP_1) ||
                              (interp_factor_i == INTERP_2) ||
                              (interp_factor_i == INTERP_4) ||
                              (interp_factor_i == INTERP_8));
      end
   end

   // read mux; reserved bits and unmapped offsets read zero
   always_comb begin
      rd_mux = READ_ZERO;
      if (reg_addr_i == OFS_CFG_CHECK) begin
         rd_mux[CHK_SUBCLASS_BIT] = chk_subclass_ff;
         rd_mux[CHK_INTERP_BIT]   = chk_interp_ff;
      end else if (reg_addr_i == OFS_WINDOW) begin
         rd_mux[WIN_W-1:0] = window_ff;
      end else if (reg_addr_i == OFS_LAST_LO) begin
         rd_mux[ERR_W-1:0] = last_err_ff;
      end else if (reg_addr_i == OFS_LAST_HI) begin
         rd_mux[HI_UNDER_BIT] = under_ff;
         rd_mux[HI_OVER_BIT]  = over_ff;
      end else if (reg_addr_i == OFS_CTRL) begin
         rd_mux = ctrl_ff;
      end else if (reg_addr_i == OFS_STATUS) begin
         rd_mux[ST_BUSY_BIT]   = busy;
         rd_mux[ST_LOCK_BIT]   = lock_ff;
         rd_mux[ST_ROTATE_BIT] = rotate_ff;
         rd_mux[ST_WLIM_BIT]   = wlim_ff;
         rd_mux[ST_TRIP_BIT]   = trip_ff;
      end else if (reg_addr_i == OFS_LIVE) begin
         rd_mux[ERR_W-1:0] = live_err_ff;
      end
   end

   always_ff @(posedge mclk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         reg_rdata_o <= READ_ZERO;
      end else if (reg_rd_i) begin
         reg_rdata_o <= rd_mux;
      end
   end

   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (!arst_n_i);

   AST_SUBCLASS_FLAG: assert property (
      reg_rd_i && (reg_addr_i == OFS_CFG_CHECK) |=>
      reg_rdata_o[CHK_SUBCLASS_BIT] == ($past(subclass_i, 2) > SUBCLASS_1))
      else $error("subclass check flag wrong");

   AST_INTERP_FLAG: assert property (
      (interp_factor_i == INTERP_4) ##1 (interp_factor_i == INTERP_4) |->
      !chk_interp_ff)
      else $error("supported interpolation flagged");

   AST_INSIDE_NO_ADJ: assert property (
      sref_live && !outside |=> state_ff != ST_ADJUST)
      else $error("adjustment inside window");

   AST_OUTSIDE_ADJ: assert property (
      sref_live && outside && mode_cont && (state_ff == ST_IDLE) |=>
      (state_ff == ST_ADJUST) ##1 (cnt_ff == ALIGN_RELOAD))
      else $error("continuous mode missed adjustment");

   AST_RECORD_MATCH: assert property (
      state_ff == ST_ADJUST |-> last_err_ff == live_err_ff)
      else $error("recorded error differs from live error");

   AST_UNDER_FLAG: assert property (
      start_adjust && below |=> under_ff && !over_ff)
      else $error("under flag not recorded");

   AST_OVER_FLAG: assert property (
      start_adjust && above |=> over_ff && !under_ff)
      else $error("over flag not recorded");

   AST_DISABLED_IDLE: assert property (
      !align_on && (state_ff != ST_ADJUST) |=> state_ff != ST_ADJUST)
      else $error("adjustment while disabled");

   AST_ARM: assert property (
      arm_req && (state_ff == ST_IDLE) && !start_adjust |=>
      state_ff == ST_ARMED)
      else $error("arming write ignored");

   AST_CLR_STICKY: assert property (
      clr_sticky_pulse && !trip_event && (state_ff != ST_ADJUST) |=>
      !trip_ff && !rotate_ff)
      else $error("sticky bits not cleared");

   AST_CLR_LAST: assert property (
      clr_last_pulse && !start_adjust |=>
      (last_err_ff == ERR_ZERO) && !under_ff && !over_ff)
      else $error("recorded error not cleared");

   AST_HELD_BIT: assert property (
      ctrl_ff[CTRL_CLR_LAST_BIT] && $past(ctrl_ff[CTRL_CLR_LAST_BIT]) |->
      !clr_last_pulse)
      else $error("clear repeated while bit held");

   AST_MONITOR_ONLY: assert property (
      (mode == MODE_MONITOR) && sref_live |=> state_ff != ST_ADJUST)
      else $error("monitor mode adjusted clocks");

   AST_LIVE_ZERO: assert property (
      state_ff == ST_ADJUST |=> live_err_ff == ERR_ZERO)
      else $error("live error not zeroed");

   AST_TRIP_SET: assert property (
      trip_event |=> trip_ff [*2])
      else $error("trip bit not held");

   AST_BUSY_READ: assert property (
      reg_rd_i && (reg_addr_i == OFS_STATUS) && (state_ff != ST_IDLE) |=>
      reg_rdata_o[ST_BUSY_BIT])
      else $error("busy not reported");

   COV_ADJUST: cover property (state_ff == ST_ADJUST);
   COV_TRIP_INSIDE: cover property (trip_event && !outside);
   COV_UNDER: cover property (start_adjust && below);
   COV_CLR_LAST: cover property (clr_last_pulse);

endmodule : lmfc_align_ctrl

// ===== lmfc_align_pkg.sv
// constants, register map and state type of the lmfc alignment control
// Functional notes
// - flag subclass other than 0 or 1
// - flag interpolation factor not 1, 2, 4, 8
// - writable two-bit window suppresses small adjustments
// - tolerance is plus or minus window cycles
// - record 4-bit signed error on adjustment
// - last-under flag in high bit 7
// - last-over flag in high bit 6
// - control bit 7 enables logic, resets off
// - writing control bit 6 arms one-shot
// - rising bit 5 clears rotate and trip
// - rising bit 4 clears recorded error, flags
// - mode field selects one-shot, continuous, monitor
// - adjustment moves live error, zeroes it
// - armed logic seeing sysref sets trip
// - busy bit while state machine operates
package lmfc_align_pkg;

   localparam int ADDR_W     = 8;
   localparam int DATA_W     = 8;
   localparam int WIN_W      = 2;
   localparam int ERR_W      = 4;
   localparam int MODE_W     = 4;
   localparam int SUBCLASS_W = 3;
   localparam int INTERP_W   = 4;

   // register offsets
   localparam logic [ADDR_W-1:0] OFS_CFG_CHECK = 8'h30;
   localparam logic [ADDR_W-1:0] OFS_WINDOW    = 8'h34;
   localparam logic [ADDR_W-1:0] OFS_LAST_LO   = 8'h38;
   localparam logic [ADDR_W-1:0] OFS_LAST_HI   = 8'h39;
   localparam logic [ADDR_W-1:0] OFS_CTRL      = 8'h3A;
   localparam logic [ADDR_W-1:0] OFS_STATUS    = 8'h3B;
   localparam logic [ADDR_W-1:0] OFS_LIVE      = 8'h3C;

   // field positions
   localparam int CTRL_ENABLE_BIT     = 7;
   localparam int CTRL_ARM_BIT        = 6;
   localparam int CTRL_CLR_STICKY_BIT = 5;
   localparam int CTRL_CLR_LAST_BIT   = 4;
   localparam int HI_UNDER_BIT        = 7;
   localparam int HI_OVER_BIT         = 6;
   localparam int ST_BUSY_BIT         = 7;
   localparam int ST_LOCK_BIT         = 3;
   localparam int ST_ROTATE_BIT       = 2;
   localparam int ST_WLIM_BIT         = 1;
   localparam int ST_TRIP_BIT         = 0;
   localparam int CHK_SUBCLASS_BIT    = 1;
   localparam int CHK_INTERP_BIT      = 0;

   // reset values
   localparam logic [DATA_W-1:0] CTRL_RESET   = 8'h00;
   localparam logic [WIN_W-1:0]  WINDOW_RESET = 2'h0;
   localparam logic [ERR_W-1:0]  ERR_ZERO     = 4'h0;
   localparam logic [DATA_W-1:0] READ_ZERO    = 8'h00;

   // alignment modes
   localparam logic [MODE_W-1:0] MODE_ONE_SHOT     = 4'h1;
   localparam logic [MODE_W-1:0] MODE_CONTINUOUS   = 4'h2;
   localparam logic [MODE_W-1:0] MODE_MONITOR      = 4'h8;
   localparam logic [MODE_W-1:0] MODE_ONE_SHOT_MON = 4'h9;

   // supported configuration values
   localparam logic [SUBCLASS_W-1:0] SUBCLASS_0 = 3'h0;
   localparam logic [SUBCLASS_W-1:0] SUBCLASS_1 = 3'h1;
   localparam logic [INTERP_W-1:0]   INTERP_1   = 4'h1;
   localparam logic [INTERP_W-1:0]   INTERP_2   = 4'h2;
   localparam logic [INTERP_W-1:0]   INTERP_4   = 4'h4;
   localparam logic [INTERP_W-1:0]   INTERP_8   = 4'h8;

   // lmfc counter: period of 16 cycles, so the count is the signed error
   localparam logic [ERR_W-1:0] CNT_STEP     = 4'h1;
   localparam logic [ERR_W-1:0] LMFC_EDGE    = 4'h0;
   // sysref seen at count 0 lies two cycles before the reload takes effect
   localparam logic [ERR_W-1:0] ALIGN_RELOAD = 4'h2;

   typedef enum logic [1:0] {
      ST_IDLE,
      ST_ARMED,
      ST_ADJUST
   } align_state_type;

endpackage : lmfc_align_pkg

// ===== rise_detect.sv
// one-cycle pulse on a 0-to-1 transition of a same-domain level
`timescale 1ns/1ps
module rise_detect (
   // clock and reset
   input  wire logic mclk_i,
   input  wire logic arst_n_i,
   // level and pulse
   input  wire logic d_i,
   output logic      rise_o
);

   logic prev_ff;

   always_ff @(posedge mclk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         prev_ff <= 1'b0;
      end else begin
         prev_ff <= d_i;
      end
   end

   assign rise_o = d_i & ~prev_ff;

endmodule : rise_detect

// ===== sysref_src.sv
// sysref source model that drives the pin of the alignment block
`timescale 1ns/1ps
module sysref_src (
   // clock
   input  wire logic mclk_i,
   // sysref pin
   output logic      sysref_o
);
   localparam int HIGH_CYCLES = 4;

   initial sysref_o = 1'b0;

   // wide enough to pass the two-flop synchroniser with margin
   task automatic fire();
      sysref_o = 1'b1;
      repeat (HIGH_CYCLES) @(posedge mclk_i);
      #1;
      sysref_o = 1'b0;
   endtask : fire
endmodule : sysref_src

// ===== tb.sv
// self-checking testbench of the lmfc alignment control
`timescale 1ns/1ps
module tb;
   import lmfc_align_pkg::*;
   localparam time DLY = 1;
   logic                  mclk_i          = 1'b0;
   logic                  arst_n_i        = 1'b0;
   logic                  sysref_i;
   logic [SUBCLASS_W-1:0] subclass_i      = SUBCLASS_1;
   logic [INTERP_W-1:0]   interp_factor_i = INTERP_2;
   logic                  reg_wr_i        = 1'b0;
   logic                  reg_rd_i        = 1'b0;
   logic [ADDR_W-1:0]     reg_addr_i      = 8'h00;
   logic [DATA_W-1:0]     reg_wdata_i     = 8'h00;
   logic [DATA_W-1:0]     reg_rdata_o;
   logic                  lmfc_pulse_o;
   int                    err_count       = 0;
   int                    n_compared      = 0;
   int                    cyc             = 0;
   int                    ref_cyc;
   logic [DATA_W-1:0]     v;
   logic [DATA_W-1:0]     hi;
   logic [ERR_W-1:0]      last;
   logic [DATA_W-1:0]     m;
   bit                    os;
   int tw[10] = '{0, 0, 2, 2, 2, 1, 1, 0, 0, 0};
   int td[10] = '{3, 0, 2, -2, 3, -2, -1, 7, 8, -1};
   bit ta[10] = '{1, 0, 0, 0, 1, 1, 0, 1, 1, 1};
   bit tu[10] = '{0, 0, 0, 0, 0, 1, 0, 0, 1, 1};
   logic [DATA_W-1:0] mt[5] = '{8'h01, 8'h09, 8'h08, 8'h02, 8'h00};
   bit ma1[5] = '{1, 1, 0, 1, 0};
   bit ma2[5] = '{0, 0, 0, 1, 0};

   lmfc_align_ctrl u_lmfc_align_ctrl (
      .mclk_i          (mclk_i),
      .arst_n_i        (arst_n_i),
      .sysref_i        (sysref_i),
      .subclass_i      (subclass_i),
      .interp_factor_i (interp_factor_i),
      .reg_wr_i        (reg_wr_i),
      .reg_rd_i        (reg_rd_i),
      .reg_addr_i      (reg_addr_i),
      .reg_wdata_i     (reg_wdata_i),
      .reg_rdata_o     (reg_rdata_o),
      .lmfc_pulse_o    (lmfc_pulse_o)
   );

   sysref_src u_sysref_src (
      .mclk_i   (mclk_i),
      .sysref_o (sysref_i)
   );

   always #20 mclk_i = ~mclk_i;
   always @(posedge mclk_i) cyc <= cyc + 1;

   task automatic chk(input logic [DATA_W-1:0] got,
                      input logic [DATA_W-1:0] exp, input string what);
      n_compared++;
      if (got !== exp) begin
         err_count++;
         $display("MISMATCH at %0t: %s got %h exp %h", $time, what, got, exp);
      end
   endtask : chk

   task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
      @(posedge mclk_i);
      #DLY;
      reg_wr_i = 1'b1;
      reg_addr_i = a;
      reg_wdata_i = d;
      @(posedge mclk_i);
      #DLY;
      reg_wr_i = 1'b0;
   endtask : wr

   task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
      @(posedge mclk_i);
      #DLY;
      reg_rd_i = 1'b1;
      reg_addr_i = a;
      @(posedge mclk_i);
      #DLY;
      reg_rd_i = 1'b0;
      d = reg_rdata_o;
   endtask : rd

   // spacing of 16*n after an adjustment makes d the exact phase error;
   // a fire without adjustment moves the reference on by a whole 64 so
   // the next target still lies ahead of cyc and keeps the same phase
   task automatic fire_at(input int d, input bit adj);
      int target;
      target = ref_cyc + 64 + d;
      wait (cyc == target);
      #DLY;
      u_sysref_src.fire();
      repeat (6) @(posedge mclk_i);
      if (adj) begin
         ref_cyc = target;
         last = d[3:0];
      end else begin
         ref_cyc = ref_cyc + 64;
      end
   endtask : fire_at

   task automatic summarize();
      $display("compared %0d, mismatches %0d", n_compared, err_count);
      if (err_count == 0 && n_compared > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : summarize

   initial begin
      repeat (5000) @(posedge mclk_i);
      err_count++;
      $display("MISMATCH at %0t: watchdog expired", $time);
      summarize();
   end

   initial begin
      repeat (3) @(posedge mclk_i);
      #DLY;
      arst_n_i = 1'b1;
      for (int i = 0; i < 16; i++) begin
         subclass_i = i[2:0];
         interp_factor_i = i[3:0];
         repeat (3) @(posedge mclk_i);
         rd(OFS_CFG_CHECK, v);
         chk(v & 8'h02, (i % 8 > 1) ? 8'h02 : 8'h00, "subclass");
         chk(v & 8'h01, (i inside {1, 2, 4, 8}) ? 8'h00 : 8'h01, "interp");
      end
      subclass_i = SUBCLASS_1;
      interp_factor_i = INTERP_2;
      rd(OFS_WINDOW, v);
      chk(v, 8'h00, "window reset");
      rd(OFS_LAST_HI, v);
      chk(v, 8'h00, "last hi reset");
      rd(OFS_CTRL, v);
      chk(v, 8'h00, "ctrl reset");
      wr(OFS_WINDOW, 8'hFF);
      rd(OFS_WINDOW, v);
      chk(v, 8'h03, "window width");
      wr(OFS_LAST_LO, 8'h55);
      rd(OFS_LAST_LO, v);
      chk(v, 8'h00, "last lo read-only");
      rd(8'h35, v);
      chk(v, 8'h00, "unmapped");
      // continuous mode but logic off: sysref must change nothing
      wr(OFS_WINDOW, 8'h00);
      wr(OFS_CTRL, 8'h02);
      ref_cyc = cyc - 60;
      fire_at(0, 0);
      rd(OFS_STATUS, v);
      chk(v, 8'h00, "status while disabled");
      rd(OFS_LIVE, v);
      chk(v, 8'h00, "live while disabled");
      // first adjustment fixes the lmfc phase reference
      wr(OFS_CTRL, 8'h82);
      @(posedge mclk_i iff lmfc_pulse_o);
      ref_cyc = cyc - 59;
      fire_at(0, 1);
      hi = 8'h00;
      for (int i = 0; i < 10; i++) begin
         wr(OFS_WINDOW, tw[i][7:0]);
         wr(OFS_CTRL, 8'hA2);
         wr(OFS_CTRL, 8'h82);
         // reload of 2 puts the lmfc edge 2 cycles after each 16 from ref
         wait (cyc == ref_cyc + 50);
         #DLY;
         chk({7'h00, lmfc_pulse_o}, 8'h01, "lmfc edge");
         @(posedge mclk_i);
         #DLY;
         chk({7'h00, lmfc_pulse_o}, 8'h00, "lmfc after edge");
         fire_at(td[i], ta[i]);
         if (ta[i]) hi = {tu[i], ~tu[i], 6'h00};
         rd(OFS_LAST_LO, v);
         chk(v, {4'h0, last}, "last error");
         rd(OFS_LAST_HI, v);
         chk(v, hi, "under/over");
         rd(OFS_LIVE, v);
         chk(v, ta[i] ? 8'h00 : {4'h0, td[i][3:0]}, "live");
         rd(OFS_STATUS, v);
         chk(v, ta[i] ? 8'h06 : 8'h08, "rotated");
      end
      wr(OFS_CTRL, 8'h92);
      rd(OFS_LAST_HI, v);
      chk(v, 8'h00, "clear hi");
      fire_at(5, 1);
      wr(OFS_CTRL, 8'h92);
      rd(OFS_LAST_LO, v);
      chk(v, 8'h05, "held clear bit");
      wr(OFS_CTRL, 8'h82);
      wr(OFS_CTRL, 8'h92);
      rd(OFS_LAST_LO, v);
      chk(v, 8'h00, "clear lo");
      last = 4'h0;
      for (int i = 0; i < 5; i++) begin
         m = mt[i];
         os = (m == 8'h01) || (m == 8'h09);
         wr(OFS_CTRL, 8'hA0 | m);
         wr(OFS_CTRL, 8'hC0 | m);
         rd(OFS_STATUS, v);
         if (os) chk(v & 8'h85, 8'h80, "armed busy");
         fire_at(3, ma1[i]);
         rd(OFS_LAST_LO, v);
         chk(v, {4'h0, last}, "mode first");
         rd(OFS_STATUS, v);
         chk(v & 8'h04, ma1[i] ? 8'h04 : 8'h00, "mode rotated");
         if (os) chk(v & 8'h81, 8'h01, "tripped");
         fire_at(5, ma2[i]);
         rd(OFS_LAST_LO, v);
         chk(v, {4'h0, last}, "mode second");
      end
      summarize();
   end
endmodule : tb
